// ==== src/posm_pkg.sv ====
// shared constants for the pin output source mux with lock
package posm_pkg;
  localparam int          SEL_W          = 5;
  localparam int          REG_W          = 8;
  localparam int          NUM_PINS       = 18;
  localparam logic [4:0]  CODE_MOD       = 5'h1F;
  localparam logic [4:0]  CODE_REFCLK    = 5'h1E;
  localparam int          NUM_GEN_SRC    = 30;
  localparam logic [11:0] ADDR_LOCK      = 12'h000;
  localparam logic [11:0] ADDR_SEL_BASE  = 12'h004;
  localparam int          LOCK_BIT       = 0;
  localparam logic [4:0]  SEL_RESET      = 5'h00;
  localparam logic        LOCK_RESET     = 1'b0;
endpackage

// ==== src/posm_sel_if.sv ====
// selection fields and source signals carried between the register file and the pin muxes
`timescale 1ns/100ps
interface posm_sel_if #(
  parameter int NUM_PINS = posm_pkg::NUM_PINS
);
  logic [NUM_PINS-1:0][posm_pkg::SEL_W-1:0] pinSel;
  logic [posm_pkg::NUM_GEN_SRC-1:0]         genSrc;
  logic                                     modOut;
  logic                                     refClkOut;
  logic [NUM_PINS-1:0]                      pinOut;

  modport regs (output pinSel, output genSrc, output modOut, output refClkOut, input pinOut);
  modport mux  (input pinSel, input genSrc, input modOut, input refClkOut, output pinOut);
endinterface

// ==== src/posm_pin_mux.sv ====
// one registered source multiplexer per remappable output pin
`timescale 1ns/100ps
module posm_pin_mux #(
  parameter int NUM_PINS = posm_pkg::NUM_PINS
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  posm_sel_if.mux   sel
);
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic srcD;
    logic outQ;
    always_comb begin
      if (sel.pinSel[p] == posm_pkg::CODE_MOD) begin
        srcD = sel.modOut;
      end else if (sel.pinSel[p] == posm_pkg::CODE_REFCLK) begin
        srcD = sel.refClkOut;
      end else begin
        srcD = sel.genSrc[sel.pinSel[p]];
      end
    end
    // registered so the pin never glitches while the select bits change
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        outQ <= 1'b0;
      end else begin
        outQ <= srcD;
      end
    end
    assign sel.pinOut[p] = outQ;
  end
endmodule // posm_pin_mux

// ==== src/posm_remap.sv ====
// peripheral pin remap output side: APB registers, lock and per-pin source muxes
// How it works
// - each pin select register holds a 5-bit field; bits 7-5 read zero.
// - select code 11111 routes the data signal modulator output to the pin.
// - select code 11110 routes the reference clock output to the pin.
// - select field clears on power-on/brown-out reset, holds on other resets.
// - while the lock bit is set, writes to select registers are refused.
// - lock clear accepts select writes; lock is read/write, clears on every reset.
// - lock register bits 7-1 ignore writes and read zero.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module posm_remap #(
  parameter int NUM_PINS = posm_pkg::NUM_PINS
) (
  input  wire logic                              sys_clk,
  input  wire logic                              arst_n,
  input  wire logic                              otherRst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic [31:0]                            prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [posm_pkg::NUM_GEN_SRC-1:0]  periphOut,
  input  wire logic                              dataSignalModulatorOut,
  input  wire logic                              referenceClockOut,
  output logic [NUM_PINS-1:0]                    pinOut,
  output logic                                   remapLockedFlag
);
  posm_sel_if #(.NUM_PINS(NUM_PINS)) selBus ();

  logic [NUM_PINS-1:0][posm_pkg::SEL_W-1:0] pinSelQ;
  logic                                     lockQ;
  logic [31:0]                              rdataQ;
  logic                                     errQ;

  logic        setupPh;
  logic        accessWr;
  logic        hitLock;
  logic        hitSel;
  logic [11:0] selOffs;
  logic [11:0] selIdx;

  assign setupPh  = psel & ~penable;
  assign accessWr = psel & penable & pwrite & pstrb[0];
  assign hitLock  = (paddr == posm_pkg::ADDR_LOCK);
  assign selOffs  = paddr - posm_pkg::ADDR_SEL_BASE;
  assign selIdx   = {2'b00, selOffs[11:2]};
  assign hitSel   = (paddr >= posm_pkg::ADDR_SEL_BASE) && (paddr[1:0] == 2'b00)
                    && (selIdx < 12'(NUM_PINS));

  // lock: cleared by any reset kind
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lockQ <= posm_pkg::LOCK_RESET;
    end else if (otherRst) begin
      lockQ <= posm_pkg::LOCK_RESET;
    end else if (accessWr && hitLock) begin
      lockQ <= pwdata[posm_pkg::LOCK_BIT];
    end
  end

  // selections: only power-on/brown-out clears them, other resets leave them alone
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_sel
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        pinSelQ[p] <= posm_pkg::SEL_RESET;
      end else if (accessWr && hitSel && (selIdx == 12'(p)) && !lockQ && !otherRst) begin
        pinSelQ[p] <= pwdata[posm_pkg::SEL_W-1:0];
      end
    end
  end

  // read data captured in setup so the zero-wait access phase presents a flopped value
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdataQ <= 32'h0000_0000;
      errQ   <= 1'b0;
    end else if (setupPh) begin
      rdataQ <= 32'h0000_0000;
      errQ   <= ~(hitLock | hitSel);
      if (hitLock) begin
        rdataQ[posm_pkg::LOCK_BIT] <= lockQ;
      end else if (hitSel) begin
        rdataQ[posm_pkg::SEL_W-1:0] <= pinSelQ[selIdx[4:0]];
      end
    end
  end

  assign pready          = 1'b1;
  assign prdata          = rdataQ;
  assign pslverr         = psel & penable & errQ;
  assign remapLockedFlag = lockQ;

  assign selBus.pinSel  = pinSelQ;
  assign selBus.genSrc  = periphOut;
  assign selBus.modOut    = dataSignalModulatorOut;
  assign selBus.refClkOut = referenceClockOut;
  assign pinOut         = selBus.pinOut;

  posm_pin_mux #(.NUM_PINS(NUM_PINS)) u_mux (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .sel     (selBus.mux)
  );
endmodule // posm_remap

// ==== sim/posm_src_model.sv ====
// peripheral and pin source pattern model
`timescale 1ns/100ps
module posm_src_model (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  output logic      [31:0] src_q
);
  // shifts left each cycle, feeding back the inverted top bit and flipping every even bit, so a wrong source shows up
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) src_q <= '0;
    else src_q <= {src_q[30:0], ~src_q[31]} ^ 32'h5555_5555;
endmodule // posm_src_model

// ==== sim/posm_remap_props.sv ====
// port assertions for the remap block
`timescale 1ns/100ps
module posm_remap_chk #(parameter int NUM_PINS = posm_pkg::NUM_PINS) (
  input wire logic sys_clk, arst_n, otherRst, psel, penable, pwrite, pslverr,
  input wire logic dataSignalModulatorOut, referenceClockOut, remapLockedFlag,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire logic [29:0] periphOut,
  input wire logic [NUM_PINS-1:0] pinOut
);
  logic [4:0] s_q;
  wire rdA = psel && penable && !pwrite;
  wire wrA = psel && penable && pwrite && pstrb[0] && !otherRst;
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) s_q <= '0;
    else if (wrA && paddr == 12'h004 && !remapLockedFlag) s_q <= pwdata[4:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_sel_read: assert property (rdA && paddr == 12'h004 |-> prdata == {27'h0, s_q})
    else $error("sel");
  a_lock_read: assert property (rdA && paddr == 12'h000 |-> prdata == {31'h0, remapLockedFlag})
    else $error("lock");
  a_lock_write: assert property (wrA && paddr == 12'h000 |=> remapLockedFlag == $past(pwdata[0]))
    else $error("lockw");
  a_lock_clear: assert property (otherRst |=> !remapLockedFlag) else $error("lockc");
  a_pin_dsm: assert property (s_q == 5'h1F |=> pinOut[0] == $past(dataSignalModulatorOut))
    else $error("dsm");
  a_pin_reference_clock_out: assert property (s_q == 5'h1E |=> pinOut[0] == $past(referenceClockOut))
    else $error("reference_clock_out");
  a_pin_gen: assert property (s_q < 5'h1E |=> pinOut[0] == $past(periphOut[s_q]))
    else $error("gen");
  a_bad_addr: assert property (psel && penable && paddr > 12'h048 |-> pslverr) else $error("err");
endmodule // posm_remap_chk
bind posm_remap posm_remap_chk #(.NUM_PINS(NUM_PINS)) posm_remap_chk_inst (.*);

// ==== sim/tb_top.sv ====
// self-checking bench for the remap block
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 0, arst_n = 0, otherRst = 0, psel = 0, penable = 0, pwrite = 0, perr, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rows [5] = '{32'hFF, 32'h1E, 32'h0, 32'h1D, 32'hE7};
  logic [4:0] c;
  logic pready, pslverr, remapLockedFlag;
  logic [17:0] pinOut;
  wire [31:0] src;
  int err_total = 0, samples_checked = 0;
  posm_src_model posm_src_model_inst (.sys_clk, .arst_n, .src_q(src));
  posm_remap posm_remap_inst (.sys_clk, .arst_n, .otherRst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'h1), .prdata, .pready, .pslverr, .periphOut(src[29:0]),
    .dataSignalModulatorOut(src[30]), .referenceClockOut(src[31]), .pinOut, .remapLockedFlag);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk) penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      if (i == 20) begin err_total++; test_done(); end
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata; perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    apb(0, 12'h004, 0); chk(rd, '0);
    apb(0, 12'h000, 0); chk(rd, '0);
    chk({31'h0, pready}, 32'h1);
    foreach (rows[i]) begin
      c = rows[i][4:0];
      apb(1, 12'h004, rows[i]); apb(1, 12'h048, rows[i]);
      apb(0, 12'h048, 0); chk(rd, {27'h0, c});
      repeat (3) begin
        @(negedge sys_clk) e = src[c == 5'h1F ? 30 : c == 5'h1E ? 31 : c];
        @(posedge sys_clk) #1 chk({30'h0, pinOut[17], pinOut[0]}, {30'h0, e, e});
      end
    end
    apb(1, 12'h000, 32'hFF); apb(0, 12'h000, 0); chk(rd, 32'h1);
    chk({31'h0, remapLockedFlag}, 32'h1);
    apb(1, 12'h004, 32'h1F); apb(0, 12'h004, 0); chk(rd, 32'h7);
    @(posedge sys_clk) otherRst <= 1'b1;
    @(posedge sys_clk) otherRst <= 1'b0;
    apb(0, 12'h000, 0); chk(rd, '0);
    chk({31'h0, remapLockedFlag}, 32'h0);
    apb(1, 12'h004, 32'h1E); apb(0, 12'h004, 0); chk(rd, 32'h1E);
    apb(0, 12'h04C, 0); chk({31'h0, perr}, 32'h1);
    // power-on reset in mid-run must clear the kept selection
    @(posedge sys_clk) arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    apb(0, 12'h004, 0); chk(rd, '0);
    test_done();
  end
endmodule // tb_top
